// file: core/fault_irq_pkg.sv
`default_nettype none
package fault_irq_pkg;

  // Bus geometry
  localparam int                ADDR_WIDTH           = 8;
  localparam int                DATA_WIDTH           = 32;
  localparam int                REG_WIDTH            = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0]        LED_FAULT_CONFIG_IDX = 8'h06;
  localparam logic [7:0]        SUPPLY_IRQ_EN_IDX    = 8'h08;
  localparam logic [7:0]        SUPPLY_IRQ_STAT_IDX  = 8'h10;
  localparam logic [7:0]        SUPPLY_IRQ_CLR_IDX   = 8'h11;
  localparam logic [7:0]        LED_FAULT_CONFIG_ADDR = 8'h18;
  localparam logic [7:0]        SUPPLY_IRQ_EN_ADDR    = 8'h20;
  localparam logic [7:0]        SUPPLY_IRQ_STAT_ADDR  = 8'h40;
  localparam logic [7:0]        SUPPLY_IRQ_CLR_ADDR   = 8'h44;

  // Reset values
  localparam logic [15:0]       LED_FAULT_CONFIG_RST = 16'h0100;
  localparam logic [15:0]       SUPPLY_IRQ_EN_RST    = 16'h2aaa;

  // Fault configuration fields
  localparam int                GROUND_DETECT_BIT    = 8;
  localparam int                STRING_ONE_BIT       = 0;
  localparam int                STRING_TWO_BIT       = 1;
  localparam int                STRING_THREE_BIT     = 2;
  localparam int                STRING_FOUR_BIT      = 3;

  // Supply interrupt fields: field k occupies bits 2k+1..2k
  localparam int                NUM_SUPPLY_IRQ       = 7;
  localparam int                IRQ_UNDERVOLTAGE     = 0;
  localparam int                IRQ_OVERVOLTAGE      = 1;
  localparam int                IRQ_CORE_UNDERVOLT   = 2;
  localparam int                IRQ_OVERCURRENT      = 3;
  localparam int                IRQ_PUMP_CAP_MISSING = 4;
  localparam int                IRQ_CHARGE_PUMP      = 5;
  localparam int                IRQ_SYNC_MISSING     = 6;
  localparam int                RESERVED_FIELD_LSB   = 14;

  // Field codes
  localparam logic [1:0]        CODE_READ_OFF        = 2'h0;
  localparam logic [1:0]        CODE_READ_ON         = 2'h2;
  localparam logic [1:0]        CODE_WRITE_OFF       = 2'h1;
  localparam logic [1:0]        CODE_WRITE_ON        = 2'h3;

  // AXI responses
  localparam logic [1:0]        RESP_OKAY            = 2'h0;
  localparam logic [1:0]        RESP_DECERR          = 2'h3;

endpackage : fault_irq_pkg
`default_nettype wire

// file: core/supply_irq_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface supply_irq_ctrl_if;
  logic        enable_write;
  logic        clear_write;
  logic [15:0] write_data;
  logic [1:0]  write_lanes;
  logic [15:0] enable_read;
  logic [15:0] status_read;

  modport regs (
    output enable_write,
    output clear_write,
    output write_data,
    output write_lanes,
    input  enable_read,
    input  status_read
  );

  modport unit (
    input  enable_write,
    input  clear_write,
    input  write_data,
    input  write_lanes,
    output enable_read,
    output status_read
  );
endinterface : supply_irq_ctrl_if
`default_nettype wire

// file: core/supply_irq_unit.sv
`timescale 1ns/1ps
`default_nettype none
module supply_irq_unit (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Register side
  supply_irq_ctrl_if.unit            ctrl,
  // Supply fault events
  input  wire logic [6:0]            supply_fault_event,
  // Interrupt
  output logic                       irq
);

  logic [6:0] irq_enable;
  logic [1:0] reserved_bits;
  logic [6:0] irq_status;
  logic [6:0] clear_bits;

  // Codes 0h and 2h leave a field alone so one field can be set in isolation
  function automatic logic next_enable(input logic [1:0] code, input logic cur);
    case (code)
      fault_irq_pkg::CODE_WRITE_OFF: next_enable = 1'b0;
      fault_irq_pkg::CODE_WRITE_ON:  next_enable = 1'b1;
      default:                       next_enable = cur;
    endcase
  endfunction : next_enable

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable <= 7'h7f;
    end else if (ctrl.enable_write) begin
      for (int k = 0; k < fault_irq_pkg::NUM_SUPPLY_IRQ; k++) begin
        if (ctrl.write_lanes[k / 4]) begin
          irq_enable[k] <= next_enable(ctrl.write_data[2 * k +: 2], irq_enable[k]);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reserved_bits <= 2'h0;
    end else if (ctrl.enable_write && ctrl.write_lanes[1]) begin
      reserved_bits <= ctrl.write_data[fault_irq_pkg::RESERVED_FIELD_LSB +: 2];
    end
  end

  // Status bits sit at the high bit of each field, like the enable read code
  always_comb begin
    for (int k = 0; k < fault_irq_pkg::NUM_SUPPLY_IRQ; k++) begin
      clear_bits[k] = ctrl.clear_write && ctrl.write_lanes[k / 4]
                      && ctrl.write_data[2 * k + 1];
    end
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 7'h00;
    end else begin
      irq_status <= (irq_status & ~clear_bits) | supply_fault_event;
    end
  end

  always_comb begin
    ctrl.enable_read = 16'h0000;
    ctrl.status_read = 16'h0000;
    ctrl.enable_read[fault_irq_pkg::RESERVED_FIELD_LSB +: 2] = reserved_bits;
    for (int k = 0; k < fault_irq_pkg::NUM_SUPPLY_IRQ; k++) begin
      ctrl.enable_read[2 * k +: 2] = irq_enable[k] ? fault_irq_pkg::CODE_READ_ON
                                                   : fault_irq_pkg::CODE_READ_OFF;
      ctrl.status_read[2 * k + 1] = irq_status[k];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

endmodule : supply_irq_unit
`default_nettype wire

// file: core/fault_config_supply_irq_regs.sv
// How it works
// - Bit 8 of the fault configuration register resets to one and enables ground-short detection.
// - Bits 3 to 0 each switch off the internal short fault of strings four to one, resetting to 0.
// - Each two-bit supply interrupt field reads 0h when disabled and 2h when enabled.
// - Writing 1h to a field disables its interrupt and writing 3h enables it.
// - Bits 13-12 enable the missing sync clock interrupt and reset enabled.
// - Bits 11-10 enable the charge pump fault interrupt and reset enabled.
// - Bits 9-8 enable the missing pump capacitor interrupt and reset enabled.
// - Bits 7-6 enable the input over-current interrupt and reset enabled.
// - Bits 5-4, 3-2 and 1-0 enable core under-voltage, input over- and under-voltage, all enabled.
// - Reserved bits 15-14 of the enable register and 15-9 of the configuration reset to zero.
`timescale 1ns/1ps
`default_nettype none
module fault_config_supply_irq_regs (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Supply fault events
  input  wire logic [6:0]            supply_fault_event,
  // LED fault detector controls
  output logic                       ground_short_detect_enable,
  output logic                       string_one_short_fault_off,
  output logic                       string_two_short_fault_off,
  output logic                       string_three_short_fault_off,
  output logic                       string_four_short_fault_off,
  // Interrupt
  output logic                       irq
);

  // Write channel holding registers
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // Merged view of the write about to complete
  logic        aw_take;
  logic        w_take;
  logic        aw_have;
  logic        w_have;
  logic        write_fire;
  logic [7:0]  write_addr;
  logic [15:0] write_data;
  logic [1:0]  write_lanes;

  // Read channel
  logic        ar_take;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Register storage
  logic [15:0] led_fault_config;

  supply_irq_ctrl_if ctrl ();

  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      fault_irq_pkg::LED_FAULT_CONFIG_ADDR,
      fault_irq_pkg::SUPPLY_IRQ_EN_ADDR,
      fault_irq_pkg::SUPPLY_IRQ_STAT_ADDR,
      fault_irq_pkg::SUPPLY_IRQ_CLR_ADDR: is_mapped = 1'b1;
      default:                            is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Merge byte lanes into a 16-bit register value
  function automatic logic [15:0] merge_lanes(input logic [15:0] cur,
                                              input logic [15:0] data,
                                              input logic [1:0]  lanes);
    merge_lanes = cur;
    if (lanes[0]) begin
      merge_lanes[7:0] = data[7:0];
    end
    if (lanes[1]) begin
      merge_lanes[15:8] = data[15:8];
    end
  endfunction : merge_lanes

  // No new address or data is taken while a response waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign aw_have       = aw_held || aw_take;
  assign w_have        = w_held || w_take;
  assign write_fire    = aw_have && w_have;

  always_comb begin
    write_addr  = aw_held ? aw_addr : s_axi_awaddr;
    write_data  = w_held ? w_data[15:0] : s_axi_wdata[15:0];
    write_lanes = w_held ? w_strb[1:0] : s_axi_wstrb[1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (write_fire) begin
      aw_held <= 1'b0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (write_fire) begin
      w_held <= 1'b0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fault_irq_pkg::RESP_OKAY;
    end else if (write_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(write_addr) ? fault_irq_pkg::RESP_OKAY
                                            : fault_irq_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Reserved bits are kept as written so software reads back what it wrote
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_fault_config <= fault_irq_pkg::LED_FAULT_CONFIG_RST;
    end else if (write_fire && write_addr == fault_irq_pkg::LED_FAULT_CONFIG_ADDR) begin
      led_fault_config <= merge_lanes(led_fault_config, write_data, write_lanes);
    end
  end

  always_comb begin
    ctrl.enable_write = write_fire && write_addr == fault_irq_pkg::SUPPLY_IRQ_EN_ADDR;
    ctrl.clear_write  = write_fire && write_addr == fault_irq_pkg::SUPPLY_IRQ_CLR_ADDR;
    ctrl.write_data   = write_data;
    ctrl.write_lanes  = write_lanes;
  end

  // Detector controls follow the register directly
  always_comb begin
    ground_short_detect_enable   = led_fault_config[fault_irq_pkg::GROUND_DETECT_BIT];
    string_one_short_fault_off   = led_fault_config[fault_irq_pkg::STRING_ONE_BIT];
    string_two_short_fault_off   = led_fault_config[fault_irq_pkg::STRING_TWO_BIT];
    string_three_short_fault_off = led_fault_config[fault_irq_pkg::STRING_THREE_BIT];
    string_four_short_fault_off  = led_fault_config[fault_irq_pkg::STRING_FOUR_BIT];
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  // Clear register is write-only and reads as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = fault_irq_pkg::RESP_OKAY;
    case (s_axi_araddr)
      fault_irq_pkg::LED_FAULT_CONFIG_ADDR: next_rdata[15:0] = led_fault_config;
      fault_irq_pkg::SUPPLY_IRQ_EN_ADDR:    next_rdata[15:0] = ctrl.enable_read;
      fault_irq_pkg::SUPPLY_IRQ_STAT_ADDR:  next_rdata[15:0] = ctrl.status_read;
      fault_irq_pkg::SUPPLY_IRQ_CLR_ADDR:   next_rdata[15:0] = 16'h0000;
      default:                              next_rresp       = fault_irq_pkg::RESP_DECERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= fault_irq_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  supply_irq_unit u_supply_irq (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .ctrl               (ctrl.unit),
    .supply_fault_event (supply_fault_event),
    .irq                (irq)
  );

endmodule : fault_config_supply_irq_regs
`default_nettype wire

// file: bench/fault_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module fault_regs_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Events and controls
  input wire logic [6:0]  supply_fault_event,
  input wire logic        ground_short_detect_enable,
  input wire logic        string_one_short_fault_off,
  input wire logic        string_two_short_fault_off,
  input wire logic        string_three_short_fault_off,
  input wire logic        string_four_short_fault_off,
  input wire logic        irq
);
  logic [3:0] offs;
  assign offs = {string_four_short_fault_off, string_three_short_fault_off,
                 string_two_short_fault_off, string_one_short_fault_off};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_view_a:
    assert property (!$past(aresetn) |-> ground_short_detect_enable && offs == 4'h0
      && !irq && !s_axi_bvalid && !s_axi_rvalid) else $error("Bad state after reset");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped early");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped early");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read not answered");
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid) else $error("Write not answered");
  busy_refuse_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("Write taken while response pending");
  irq_cause_a:
    assert property ($rose(irq) |-> $past(supply_fault_event, 2) != 7'h00 || $past(s_axi_bvalid))
      else $error("Interrupt rose without cause");
  detect_change_a:
    assert property ($changed(ground_short_detect_enable) |-> $rose(s_axi_bvalid))
      else $error("Detect enable changed without write");
  string_change_a:
    assert property ($changed(offs) |-> $rose(s_axi_bvalid))
      else $error("String controls changed without write");
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : fault_regs_props
bind fault_config_supply_irq_regs fault_regs_props props (.*);
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        aclk, aresetn, irq, ground_short_detect_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, offs;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        string_one_short_fault_off, string_two_short_fault_off;
  logic        string_three_short_fault_off, string_four_short_fault_off;
  logic [6:0]  supply_fault_event;
  int          fails, num_checks;
  assign offs = {string_four_short_fault_off, string_three_short_fault_off,
                 string_two_short_fault_off, string_one_short_fault_off};
  fault_config_supply_irq_regs dut (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Ready is raised a cycle late so the slave must hold its answer
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ta, tw, bv, tb;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      bv = s_axi_bvalid;
      tb = bv && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= bv && !tb;
    end while (!tb);
    check(resp, er);
  endtask : wr
  task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, rv, tr;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      rv = s_axi_rvalid;
      tr = rv && s_axi_rready;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      s_axi_rready <= rv && !tr;
    end while (!tr);
    check(rd, e);
    check(resp, er);
  endtask : rchk
  task pulse(input int k);
    @(posedge aclk);
    supply_fault_event <= 7'h01 << k;
    @(posedge aclk);
    supply_fault_event <= 7'h00;
    @(posedge aclk);
    @(negedge aclk);
  endtask : pulse
  task t_reset;
    check({ground_short_detect_enable, offs, irq}, 6'h20);
    rchk(8'h18, 32'h0100, 2'h0);
    rchk(8'h20, 32'h2aaa, 2'h0);
    rchk(8'h40, 32'h0, 2'h0);
    rchk(8'h44, 32'h0, 2'h0);
    rchk(8'h4c, 32'h0, 2'h3);
  endtask : t_reset
  task t_config;
    wr(8'h18, 32'h000f, 4'h3, 2'h0);
    check({ground_short_detect_enable, offs}, 5'h0f);
    wr(8'h18, 32'h0105, 4'h1, 2'h0);
    check({ground_short_detect_enable, offs}, 5'h05);
    wr(8'h18, 32'h0100, 4'h2, 2'h0);
    check({ground_short_detect_enable, offs}, 5'h15);
    wr(8'h4c, 32'hffff, 4'h3, 2'h3);
    wr(8'h40, 32'hffff, 4'h3, 2'h0);
    rchk(8'h18, 32'h0105, 2'h0);
  endtask : t_config
  task t_codes;
    logic [15:0] e;
    e = 16'h2aaa;
    for (int k = 0; k < 7; k++) begin
      wr(8'h20, 32'h1 << (2 * k), 4'h3, 2'h0);
      e[2 * k + 1] = 1'b0;
      rchk(8'h20, {16'h0, e}, 2'h0);
    end
    wr(8'h20, 32'h2aaa, 4'h3, 2'h0);
    rchk(8'h20, 32'h0, 2'h0);
    wr(8'h20, 32'h3fff, 4'h3, 2'h0);
    rchk(8'h20, 32'h2aaa, 2'h0);
  endtask : t_codes
  task t_irq;
    for (int k = 0; k < 7; k++) begin
      pulse(k);
      check(irq, 1'b1);
      rchk(8'h40, 32'h2 << (2 * k), 2'h0);
      wr(8'h44, 32'h2 << (2 * k), 4'h3, 2'h0);
      wr(8'h20, 32'h1 << (2 * k), 4'h3, 2'h0);
      pulse(k);
      check(irq, 1'b0);
      wr(8'h20, 32'h3 << (2 * k), 4'h3, 2'h0);
      @(negedge aclk);
      check(irq, 1'b1);
      wr(8'h44, 32'h2 << (2 * k), 4'h3, 2'h0);
      @(negedge aclk);
      check(irq, 1'b0);
    end
  endtask : t_irq
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    #1000000;
    fails++;
    conclude;
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
    {s_axi_arvalid, s_axi_rready, supply_fault_event} = '0;
    fails = 0;
    num_checks = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_config;
    t_codes;
    t_irq;
    // A second reset in mid-run must restore every reset value
    pulse(2);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    conclude;
  end
endmodule : testbench
`default_nettype wire
